// >>> input_filter_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes inputs are asynchronous to clock.
module input_filter_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             clock,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] s1;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;
   // s1 feeds only s2, guarding against metastability
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         s1   <= RESET_VAL;
         s2   <= RESET_VAL;
         s3   <= RESET_VAL;
         dout <= RESET_VAL;
      end
      else
      begin
         s1   <= din;
         s2   <= s1;
         s3   <= s2;
         // a bit changes only when the last two stages agree
         dout <= (s2 & s3) | (dout & (s2 ^ s3));
      end
   end
endmodule : input_filter_sync

// >>> spi_dual_wiper_pkg.sv
// Shared constants for the dual wiper serial control pair: register map,
// instruction codes, host register map, timing counts and host states.
// Assumes both ends and the bench compile this package first.
// Notes on behaviour
// - Device samples input on rising clock, select low.
// - Device changes output on falling clock edge.
// - Host captures output on following rising edge.
// - Access bit 1 picks open-drain, else push-pull.
// - Select high: output released, device in standby.
// - Traffic ignored until first select falling edge.
// - Wiper code sets tap, monotonic 00h to 7Fh.
// - Both wipers reset to 40h mid-scale.
// - Wipers at 0 and 1, access at 10h.
// - Shutdown bit 6 low opens arrays, wiper low.
// - Shutdown keeps wiper codes; exit restores taps.
// - Slave only, mode 0 timing.
// - Every byte travels most significant bit first.
// - Host drives select and clock, select held low.
// - First byte: code top three, address low five.
// - Codes: nop, read/write access, read/write addressed.
// - Address 0/1 wipers, 10000 access register.
// - Write committed on select rising edge.
// - Read spans four bytes; echo third, data fourth.
// - Shifted-in data flows out for daisy chains.
// - Echo byte carries 111b then read address.
package spi_dual_wiper_pkg;
   // ----------------------------------------------------------------
   // device register map
   // ----------------------------------------------------------------
   localparam logic [4:0] ADDR_WIPER0   = 5'h00;
   localparam logic [4:0] ADDR_WIPER1   = 5'h01;
   localparam logic [4:0] ADDR_ACCESS   = 5'h10;
   localparam logic [7:0] WIPER_RESET   = 8'h40;
   localparam logic [7:0] ACCESS_RESET  = 8'h40;
   localparam logic [7:0] ACCESS_MASK   = 8'h42;
   localparam int         SHUTDOWN_N_POS = 6;
   localparam int         OUT_TYPE_POS  = 1;
   localparam logic [6:0] TAP_MAX       = 7'h7f;
   // ----------------------------------------------------------------
   // instruction codes
   // ----------------------------------------------------------------
   localparam logic [2:0] OP_NOP        = 3'h0;
   localparam logic [2:0] OP_RD_ACCESS  = 3'h1;
   localparam logic [2:0] OP_WR_ACCESS  = 3'h3;
   localparam logic [2:0] OP_RD_ADDR    = 3'h4;
   localparam logic [2:0] OP_WR_ADDR    = 3'h6;
   localparam logic [2:0] ECHO_CODE     = 3'h7;
   // ----------------------------------------------------------------
   // host register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] HOST_TX_OFS     = 8'h00;
   localparam logic [7:0] HOST_CTRL_OFS   = 8'h04;
   localparam logic [7:0] HOST_STATUS_OFS = 8'h08;
   localparam logic [7:0] HOST_RX_OFS     = 8'h0c;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int SCK_HALF_NS   = 1000;
   localparam int LEAD_NS       = 250;
   localparam int LAG_NS        = 250;
   localparam int DESELECT_NS   = 2000;
   localparam int SCK_HALF_CYC  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LEAD_CYC      = (LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LAG_CYC       = (LAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DESELECT_CYC  = (DESELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ----------------------------------------------------------------
   // host sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_LEAD = 3'b001,
      H_LOW  = 3'b010,
      H_HIGH = 3'b011,
      H_LAG  = 3'b100,
      H_GAP  = 3'b101
   } host_state_t;
endpackage : spi_dual_wiper_pkg

// >>> spi_link_chk.sv
// Checker: timing relations on the serial link between host and device ends.
// Assumes one system clock oversamples the link; reset is synchronous, active high.
module spi_link_chk (
   input wire logic clock,
   input wire logic reset,
   input wire logic csN,
   input wire logic sck,
   input wire logic sdi,
   input wire logic sdoOut,
   input wire logic sdoOeN,
   input wire logic sdo
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   // ----------------------------------------------------------------
   // device side
   // ----------------------------------------------------------------
   // filter latency is a few clocks, so only a long deselect must release
   sdo_released_a: assert property (csN [*8] |-> sdoOeN)
      else $error("data output driven while deselected");
   sdo_hold_high_a: assert property (!csN && sck && $past(sck) |-> $stable(sdoOut))
      else $error("data output moved while link clock high");
   sdo_at_rise_a: assert property ($rose(sck) |-> $stable(sdo))
      else $error("data line moved at link clock rise");
   // ----------------------------------------------------------------
   // host side
   // ----------------------------------------------------------------
   sck_idle_a: assert property (csN |-> !sck)
      else $error("link clock runs while deselected");
   lead_time_a: assert property ($fell(csN) |-> !sck [*8])
      else $error("link clock rose too soon after select");
   sck_high_a: assert property ($rose(sck) |=> sck [*8])
      else $error("link clock high phase too short");
   sck_low_a: assert property ($fell(sck) |=> !sck [*8])
      else $error("link clock low phase too short");
   sdi_stable_a: assert property (sck && $past(sck) |-> $stable(sdi))
      else $error("host data moved while link clock high");
   frame_bound_a: assert property ($fell(csN) |-> ##[1:1000] $rose(csN))
      else $error("frame did not end in time");
   deselect_gap_a: assert property ($rose(csN) |=> csN [*8])
      else $error("deselect gap too short");
endmodule : spi_link_chk

// >>> spi_link_if.sv
// Serial link between the wiper device and its host.
// Assumes an external pull-up on the data output line.
interface spi_link_if;
   logic csN;
   logic sck;
   logic sdi;
   logic sdoOut;
   logic sdoOeN;
   logic sdo;
   // released line reads high through the pull-up
   assign sdo = sdoOeN ? 1'b1 : sdoOut;
   modport device (input csN, input sck, input sdi, output sdoOut, output sdoOeN);
   modport host (output csN, output sck, output sdi, input sdo);
endinterface : spi_link_if

// >>> spi_wiper_device.sv
// Device end: serial slave control logic of the dual 128-tap wiper.
// Assumes the link pins are asynchronous; the system clock oversamples them.
module spi_wiper_device
   import spi_dual_wiper_pkg::*;
(
   input  wire logic  clock,
   input  wire logic  reset,
   spi_link_if.device link,
   output logic [6:0] wiperTap0,
   output logic [6:0] wiperTap1,
   output logic       arrayConnected,
   output logic       standby
);
   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   function automatic logic isRead(input logic [7:0] instr);
      return (instr[7:5] == OP_RD_ACCESS) || (instr[7:5] == OP_RD_ADDR);
   endfunction : isRead

   // code in top three, address in low five
   // register addressed by an instruction; access codes imply 10000
   function automatic logic [4:0] targetAddr(input logic [7:0] instr);
      if ((instr[7:5] == OP_RD_ACCESS) || (instr[7:5] == OP_WR_ACCESS))
         return ADDR_ACCESS;
      return instr[4:0];
   endfunction : targetAddr

   // true when instr writes the register at addr
   function automatic logic writesAddr(input logic [7:0] instr, input logic [4:0] addr);
      if ((instr[7:5] != OP_WR_ACCESS) && (instr[7:5] != OP_WR_ADDR))
         return 1'b0;
      return targetAddr(instr) == addr;
   endfunction : writesAddr

   // codes above 7Fh stay at the top tap, keeping the travel monotonic
   function automatic logic [6:0] tapOf(input logic [7:0] code);
      return code[7] ? TAP_MAX : code[6:0];
   endfunction : tapOf

   logic [7:0] wiper0;
   logic [7:0] wiper1;
   logic [7:0] access;
   logic [2:0] pins;
   logic       csLvl;
   logic       sckLvl;
   logic       sdiLvl;
   logic       csPrev;
   logic       sckPrev;
   logic       armed;
   logic       csFall;
   logic       csRise;
   logic       sckRise;
   logic       sckFall;
   logic       active;
   logic [2:0] bitPhase;
   logic [1:0] byteCount;
   logic       frameOk;
   logic [15:0] shiftReg;
   logic [15:0] nextShift;
   logic       pendingRead;
   logic [7:0] pendingInstr;
   logic       outBit;
   logic       pushPull;

   function automatic logic [7:0] readValue(input logic [7:0] instr);
      case (targetAddr(instr))
         ADDR_WIPER0: return wiper0;
         ADDR_WIPER1: return wiper1;
         ADDR_ACCESS: return access;
         default:     return 8'h00;
      endcase
   endfunction : readValue

   // ----------------------------------------------------------------
   // pin sampling and edge detection
   // ----------------------------------------------------------------
   input_filter_sync #(
      .WIDTH     (3),
      .RESET_VAL (3'b100)
   ) pinSync (
      .clock (clock),
      .reset (reset),
      .din   ({link.csN, link.sck, link.sdi}),
      .dout  (pins)
   );
   assign csLvl  = pins[2];
   assign sckLvl = pins[1];
   assign sdiLvl = pins[0];

   // previous filtered levels for edge finding
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         csPrev  <= 1'b1;
         sckPrev <= 1'b0;
      end
      else
      begin
         csPrev  <= csLvl;
         sckPrev <= sckLvl;
      end
   end

   assign csFall = csPrev & ~csLvl;
   assign csRise = ~csPrev & csLvl & armed;
   assign sckRise = ~sckPrev & sckLvl & ~csLvl & armed;
   assign sckFall = sckPrev & ~sckLvl & ~csLvl & armed;
   assign active  = armed & ~csLvl;

   // wait for first select fall; a select already low at reset reads as a fall once the filter passes it
   always_ff @(posedge clock)
   begin
      if (reset)
         armed <= 1'b0;
      else if (csFall)
         armed <= 1'b1;
   end

   assign standby = ~active;

   // ----------------------------------------------------------------
   // bit and byte counting
   // ----------------------------------------------------------------
   // byte count saturates at two: enough for one instruction and data pair
   always_ff @(posedge clock)
   begin
      if (reset || csFall)
      begin
         bitPhase  <= 3'h0;
         byteCount <= 2'h0;
      end
      else if (sckRise)
      begin
         bitPhase <= bitPhase + 3'h1;
         if ((bitPhase == 3'h7) && (byteCount != 2'h2))
            byteCount <= byteCount + 2'h1;
      end
   end

   // whole bytes and at least a full pair
   assign frameOk = (bitPhase == 3'h0) && (byteCount == 2'h2);

   // ----------------------------------------------------------------
   // shift path, doubling as the daisy chain delay line
   // ----------------------------------------------------------------
   // msb first shift
   assign nextShift = {shiftReg[14:0], sdiLvl};

   always_ff @(posedge clock)
   begin
      if (reset)
         shiftReg <= 16'h0000;
      else if (csFall)
         // echo of a read left over from the previous frame
         shiftReg <= pendingRead ? {ECHO_CODE, targetAddr(pendingInstr), readValue(pendingInstr)} : 16'h0000;
      else if (sckRise)
      begin
         // after two bytes a read swaps in echo and data
         if ((byteCount == 2'h1) && (bitPhase == 3'h7) && isRead(nextShift[15:8]))
            shiftReg <= {ECHO_CODE, targetAddr(nextShift[15:8]), readValue(nextShift[15:8])};
         else
            shiftReg <= nextShift;
      end
   end

   // a read still in the delay line at select rise is answered in the next frame
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         pendingRead  <= 1'b0;
         pendingInstr <= 8'h00;
      end
      else if (csRise)
      begin
         pendingRead  <= frameOk && isRead(shiftReg[15:8]);
         pendingInstr <= shiftReg[15:8];
      end
      else if (csFall)
         pendingRead <= 1'b0;
   end

   // ----------------------------------------------------------------
   // output driver
   // ----------------------------------------------------------------
   // launch on falling edge
   always_ff @(posedge clock)
   begin
      if (reset)
         outBit <= 1'b0;
      else if (csFall)
         outBit <= pendingRead ? ECHO_CODE[2] : 1'b0;
      else if (sckFall)
         outBit <= shiftReg[15];
   end

   assign pushPull    = ~access[OUT_TYPE_POS];
   assign link.sdoOut = pushPull ? outBit : 1'b0;
   assign link.sdoOeN = ~active | (~pushPull & outBit);

   // ----------------------------------------------------------------
   // register file, committed at select rise
   // ----------------------------------------------------------------
   // wiper commit, last pair in the line wins
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         wiper0 <= WIPER_RESET;
         wiper1 <= WIPER_RESET;
      end
      else if (csRise && frameOk)
      begin
         if (writesAddr(shiftReg[15:8], ADDR_WIPER0))
            wiper0 <= shiftReg[7:0];
         if (writesAddr(shiftReg[15:8], ADDR_WIPER1))
            wiper1 <= shiftReg[7:0];
      end
   end

   // only the shutdown and output type bits hold state
   always_ff @(posedge clock)
   begin
      if (reset)
         access <= ACCESS_RESET;
      else if (csRise && frameOk && writesAddr(shiftReg[15:8], ADDR_ACCESS))
         access <= shiftReg[7:0] & ACCESS_MASK;
   end

   // ----------------------------------------------------------------
   // analog controls
   // ----------------------------------------------------------------
   // shutdown forces taps low without touching the codes
   assign arrayConnected = access[SHUTDOWN_N_POS];
   assign wiperTap0 = arrayConnected ? tapOf(wiper0) : 7'h00;
   assign wiperTap1 = arrayConnected ? tapOf(wiper1) : 7'h00;
endmodule : spi_wiper_device

// >>> spi_wiper_host.sv
// Host end: AHB-Lite slave registers driving serial frames to the device.
// Assumes one AHB-Lite master, word accesses only; select and clock are made here.
module spi_wiper_host
   import spi_dual_wiper_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   spi_link_if.host         link
);
   host_state_t state;
   logic [7:0]  timer;
   logic [5:0]  bitsLeft;
   logic [31:0] txData;
   logic [31:0] txShift;
   logic [31:0] rxShift;
   logic [2:0]  byteCfg;
   logic        wrPend;
   logic [7:0]  wrAddr;
   logic        accept;
   logic        start;
   logic        sdoLvl;
   logic        done;

   // ----------------------------------------------------------------
   // bus slave: zero wait states, always OKAY
   // ----------------------------------------------------------------
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign accept    = hsel & htrans[1] & hready;

   // hsize is not checked: only whole words are used
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         wrPend <= 1'b0;
         wrAddr <= 8'h00;
      end
      else
      begin
         wrPend <= accept & hwrite;
         wrAddr <= haddr[7:0];
      end
   end

   // read data is captured at the address phase so it stands in the data phase
   always_ff @(posedge clock)
   begin
      if (reset)
         hrdata <= 32'h0000_0000;
      else if (accept && !hwrite)
      begin
         case (haddr[7:0])
            HOST_TX_OFS:     hrdata <= txData;
            HOST_CTRL_OFS:   hrdata <= {29'h0, byteCfg};
            HOST_STATUS_OFS: hrdata <= {31'h0, state != H_IDLE};
            HOST_RX_OFS:     hrdata <= rxShift;
            default:         hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // transmit word and length; a length write of 1 to 4 while idle starts a frame
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         txData  <= 32'h0000_0000;
         byteCfg <= 3'h0;
      end
      else if (wrPend)
      begin
         if (wrAddr == HOST_TX_OFS)
            txData <= hwdata;
         if ((wrAddr == HOST_CTRL_OFS) && (state == H_IDLE))
            byteCfg <= hwdata[2:0];
      end
   end

   assign start = wrPend && (wrAddr == HOST_CTRL_OFS) && (state == H_IDLE)
                  && (hwdata[2:0] != 3'h0) && (hwdata[2:0] <= 3'h4);

   // ----------------------------------------------------------------
   // frame sequencer
   // ----------------------------------------------------------------
   assign done = (timer == 8'h00);

   // host owns select and clock; every frame opens with a select fall
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         state    <= H_IDLE;
         timer    <= 8'h00;
         bitsLeft <= 6'h00;
         link.csN <= 1'b1;
         link.sck <= 1'b0;
      end
      else
      begin
         if (!done)
            timer <= timer - 8'h01;
         case (state)
            H_IDLE:
               if (start)
               begin
                  link.csN <= 1'b0;
                  bitsLeft <= {hwdata[2:0], 3'h0};
                  timer    <= 8'(LEAD_CYC - 1);
                  state    <= H_LEAD;
               end
            H_LEAD:
               if (done)
               begin
                  timer <= 8'(SCK_HALF_CYC - 1);
                  state <= H_LOW;
               end
            H_LOW:
               if (done)
               begin
                  link.sck <= 1'b1;
                  timer    <= 8'(SCK_HALF_CYC - 1);
                  state    <= H_HIGH;
               end
            H_HIGH:
               if (done)
               begin
                  link.sck <= 1'b0;
                  bitsLeft <= bitsLeft - 6'h01;
                  timer    <= (bitsLeft == 6'h01) ? 8'(LAG_CYC - 1) : 8'(SCK_HALF_CYC - 1);
                  state    <= (bitsLeft == 6'h01) ? H_LAG : H_LOW;
               end
            H_LAG:
               if (done)
               begin
                  link.csN <= 1'b1;
                  timer    <= 8'(DESELECT_CYC - 1);
                  state    <= H_GAP;
               end
            H_GAP:
               if (done)
                  state <= H_IDLE;
            default:
               state <= H_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // data shifting
   // ----------------------------------------------------------------
   input_filter_sync #(
      .WIDTH     (1),
      .RESET_VAL (1'b1)
   ) sdoSync (
      .clock (clock),
      .reset (reset),
      .din   (link.sdo),
      .dout  (sdoLvl)
   );

   assign link.sdi = txShift[31];

   // capture at our own rising edge; half period covers device and sync lag
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         txShift <= 32'h0000_0000;
         rxShift <= 32'h0000_0000;
      end
      else if (start)
      begin
         txShift <= txData;
         rxShift <= 32'h0000_0000;
      end
      else if ((state == H_LOW) && done)
         rxShift <= {rxShift[30:0], sdoLvl};
      else if ((state == H_HIGH) && done)
         // bytes leave in the order software packed them
         txShift <= {txShift[30:0], 1'b0};
   end
endmodule : spi_wiper_host

// >>> testbench.sv
// Bench: host and device ends joined on one link, driven over AHB-Lite.
// Assumes package and link interface compile first; the host makes the link clock.
module testbench
   import spi_dual_wiper_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock;
   logic        reset;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic [6:0]  wiperTap0;
   logic [6:0]  wiperTap1;
   logic        arrayConnected;
   logic        standby;
   logic [31:0] sdiSeen;
   logic [31:0] rx;
   int          err_total;
   int          checked;
   // ----------------------------------------------------------------
   // ends, link and checker
   // ----------------------------------------------------------------
   spi_link_if link ();
   spi_wiper_device spi_wiper_device_inst (.clock(clock), .reset(reset), .link(link.device),
      .wiperTap0(wiperTap0), .wiperTap1(wiperTap1), .arrayConnected(arrayConnected), .standby(standby));
   spi_wiper_host spi_wiper_host_inst (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link.host));
   spi_link_chk spi_link_chk_inst (.clock(clock), .reset(reset), .csN(link.csN), .sck(link.sck),
      .sdi(link.sdi), .sdoOut(link.sdoOut), .sdoOeN(link.sdoOeN), .sdo(link.sdo));
   // ----------------------------------------------------------------
   // clock, wire monitor, watchdog
   // ----------------------------------------------------------------
   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // host data as a device would see it, taken on link clock rises
   always @(posedge link.sck)
   begin
      if (!link.csN)
         sdiSeen <= {sdiSeen[30:0], link.sdi};
   end
   // about twenty frames of some 190 to 700 clocks each fit well inside this
   initial
   begin
      repeat (40000) @(posedge clock);
      err_total++;
      end_of_test();
   end
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one single word transfer; entered just after a rising edge
   task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data);
      hsel <= 1'b1;
      haddr <= {24'h0, addr};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      @(posedge clock);
      while (hreadyout !== 1'b1)
         @(posedge clock);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= data;
      @(posedge clock);
      while (hreadyout !== 1'b1)
         @(posedge clock);
      rx = hrdata;
   endtask : bus
   // start a frame, wait for idle, leave the received bits in rx
   task automatic frame(input logic [31:0] tx, input logic [2:0] count);
      int n;
      n = 0;
      bus(1'b1, HOST_TX_OFS, tx);
      bus(1'b1, HOST_CTRL_OFS, {29'h0, count});
      do
      begin
         bus(1'b0, HOST_STATUS_OFS, 32'h0);
         n++;
      end
      while (rx[0] !== 1'b0 && n < 1000);
      // a frame that never ends is a failure, not a silent skip
      if (n >= 1000)
         err_total++;
      bus(1'b0, HOST_RX_OFS, 32'h0);
   endtask : frame
   task automatic wr(input logic [7:0] instr, input logic [7:0] data);
      frame({instr, data, 16'h0}, 3'h2);
   endtask : wr
   // four-byte read; echo byte and data byte land in the low half
   task automatic rd(input logic [7:0] instr, input logic [15:0] exp);
      frame({instr, 24'h0}, 3'h4);
      check(rx[15:0], exp);
   endtask : rd
   task automatic end_of_test();
      if (err_total == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_of_test
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      err_total = 0;
      checked = 0;
      reset = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      check({9'h0, wiperTap1}, 16'h0040);
      check({15'h0, standby}, 16'h0001);
      rd(8'h80, 16'he040);
      wr(8'hc1, 8'h55);
      check(sdiSeen[15:0], 16'hc155);
      check({9'h0, wiperTap1}, 16'h0055);
      rd(8'h81, 16'he155);
      // read left in the delay line is answered by the next frame
      frame(32'h00008100, 3'h4);
      frame(32'h00000000, 3'h2);
      check(rx[15:0], 16'he155);
      // shutdown through the access-only write code, then the access-only read
      wr(8'h60, 8'h00);
      check({15'h0, arrayConnected}, 16'h0000);
      check({9'h0, wiperTap1}, 16'h0000);
      rd(8'h20, 16'hf000);
      // unused access bits must not stick; open-drain read still correct
      wr(8'h60, 8'hff);
      check({9'h0, wiperTap1}, 16'h0055);
      rd(8'h90, 16'hf042);
      rd(8'h81, 16'he155);
      wr(8'hd0, 8'h40);
      rd(8'h20, 16'hf040);
      // undefined address, lone instruction byte and no-operation change nothing
      wr(8'hc5, 8'haa);
      frame(32'hc0aa0000, 3'h1);
      wr(8'h00, 8'h11);
      rd(8'h80, 16'he040);
      wr(8'hc0, 8'h7f);
      check({9'h0, wiperTap0}, 16'h007f);
      wr(8'hc0, 8'h00);
      check({9'h0, wiperTap0}, 16'h0000);
      bus(1'b0, 8'h20, 32'h0);
      check(rx[15:0], 16'h0000);
      reset <= 1'b1;
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      check({9'h0, wiperTap0}, 16'h0040);
      rd(8'h80, 16'he040);
      end_of_test();
   end
endmodule : testbench
